// *** hdl/sem_error_monitor.sv ***
// error monitor register group of the serial video receiver with its register port
`timescale 1ns/1ps
// What this block does
// - Read-only packet-level flags of latest error-detection packet at bits 22:19.
// - Read-only ancillary flags of latest packet at bits 18:14.
// - Read-only full-field flags of latest packet at bits 13:9.
// - Read-only active-picture flags of latest packet at bits 8:4.
// - Bit 2 high while an ancillary packet checksum error is detected.
// - Bit 1 high when own full-field crc mismatches packet value.
// - Bit 0 high when own active-picture crc mismatches packet value.
// - Sixteen read-write count enables, reset 0, selecting counted conditions.
// - Sixteen-bit field counter, at most one increment per field with enabled error.
// - Read-only sixteen-bit cumulative crc error count over all streams.
// - One crc error indicator per stream, stream n at bit n-1.
// - Writing 1 clears a stream indicator; writing 0 leaves it.
// - Stream indicator stays set one line time after the error.
// - Sixteen-bit stable-cycle count, reset 0, required before video lock.
// - Field counter works only in standard-definition mode code 001.
// - Configuration bit reads 1 when packet processor is built in.
module sem_error_monitor #(
  parameter bit PKT_PROC_PRESENT = 1'b1
) (
  input  wire logic                    clk_in,
  input  wire logic                    reset_n_in,
  input  wire logic [7:0]              s_axi_awaddr_in,
  input  wire logic                    s_axi_awvalid_in,
  output logic                         s_axi_awready_out,
  input  wire logic [31:0]             s_axi_wdata_in,
  input  wire logic [3:0]              s_axi_wstrb_in,
  input  wire logic                    s_axi_wvalid_in,
  output logic                         s_axi_wready_out,
  output logic [1:0]                   s_axi_bresp_out,
  output logic                         s_axi_bvalid_out,
  input  wire logic                    s_axi_bready_in,
  input  wire logic [7:0]              s_axi_araddr_in,
  input  wire logic                    s_axi_arvalid_in,
  output logic                         s_axi_arready_out,
  output logic [31:0]                  s_axi_rdata_out,
  output logic [1:0]                   s_axi_rresp_out,
  output logic                         s_axi_rvalid_out,
  input  wire logic                    s_axi_rready_in,
  input  wire logic [2:0]              rx_mode_in,
  input  wire sem_pkg::sem_edh_report_s edh_report_in,
  input  wire logic                    edh_report_valid_in,
  input  wire logic                    packet_checksum_err_in,
  input  wire logic                    field_start_in,
  input  wire logic [15:0]             stream_crc_err_in,
  input  wire logic                    line_end_in,
  input  wire logic                    video_stable_in,
  output logic                         video_lock_out
);
  sem_pkg::sem_main_s st_reg;
  sem_pkg::sem_main_s st_next;
  logic [15:0]        crc_flags;
  logic [15:0]        crc_clear;
  logic               do_wr;
  logic               do_rd;
  logic               sd_mode;
  logic               hit_now;
  logic [4:0]         err_ones;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [4:0] count_ones(input logic [15:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < 16; i++) begin
      n = n + {4'h0, v[i]};
    end
    return n;
  endfunction

  function automatic logic [15:0] lane_merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                             input logic [1:0] strb);
    logic [15:0] r;
    r = old_v;
    if (strb[0]) begin
      r[7:0] = new_v[7:0];
    end
    if (strb[1]) begin
      r[15:8] = new_v[15:8];
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == sem_pkg::OFS_CONFIG || a == sem_pkg::OFS_PKT_STATUS || a == sem_pkg::OFS_COUNT_EN ||
           a == sem_pkg::OFS_FIELD_CNT || a == sem_pkg::OFS_STREAM_CRC || a == sem_pkg::OFS_LOCK_CYC;
  endfunction

  // ****************************************
  // error condition decode
  // ****************************************
  assign do_wr    = st_reg.awready && s_axi_awvalid_in && s_axi_wvalid_in;
  assign do_rd    = st_reg.arready && s_axi_arvalid_in;
  assign sd_mode  = (rx_mode_in == sem_pkg::MODE_SD);
  assign err_ones = count_ones(stream_crc_err_in);
  assign hit_now  = PKT_PROC_PRESENT && sd_mode &&
                    ((st_reg.count_en[sem_pkg::CHKSUM_EN_BIT] && packet_checksum_err_in) ||
                     (edh_report_valid_in &&
                      (st_reg.count_en[14:0] & {edh_report_in.ap_flags, edh_report_in.ff_flags,
                                                edh_report_in.anc_flags}) != 15'h0000));

  always_comb begin
    crc_clear = 16'h0000;
    if (do_wr && s_axi_awaddr_in == sem_pkg::OFS_STREAM_CRC) begin
      crc_clear = lane_merge(16'h0000, s_axi_wdata_in[15:0], s_axi_wstrb_in[1:0]);
    end
  end

  // ****************************************
  // per-stream flags and lock timer
  // ****************************************
  for (genvar g = 0; g < sem_pkg::NUM_STREAMS; g++) begin : g_stream
    sem_stream_flag u_flag (
      .clk_in      (clk_in),
      .reset_n_in  (reset_n_in),
      .err_in      (stream_crc_err_in[g]),
      .clear_in    (crc_clear[g]),
      .line_end_in (line_end_in),
      .flag_out    (crc_flags[g])
    );
  end

  sem_lock_timer u_lock (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .stable_in  (video_stable_in),
    .window_in  (st_reg.lock_cyc),
    .locked_out (video_lock_out)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_next = st_reg;
    if (edh_report_valid_in) begin
      st_next.report.pkt_flags = edh_report_in.pkt_flags;
      st_next.report.anc_flags = edh_report_in.anc_flags;
      st_next.report.ff_flags  = edh_report_in.ff_flags;
      st_next.report.ap_flags  = edh_report_in.ap_flags;
    end
    st_next.report.anc_err = edh_report_in.anc_err;
    st_next.report.ff_err  = edh_report_in.ff_err;
    st_next.report.ap_err  = edh_report_in.ap_err;
    st_next.crc_cnt = st_reg.crc_cnt + {11'h000, err_ones};
    if (field_start_in) begin
      if (st_reg.field_hit || hit_now) begin
        st_next.field_cnt = st_reg.field_cnt + 16'h0001;
      end
      st_next.field_hit = 1'b0;
    end else begin
      st_next.field_hit = st_reg.field_hit || hit_now;
    end
    // write channel
    st_next.awready = s_axi_awvalid_in && s_axi_wvalid_in && !st_reg.awready && !st_reg.bvalid;
    st_next.wready  = s_axi_awvalid_in && s_axi_wvalid_in && !st_reg.awready && !st_reg.bvalid;
    if (st_reg.bvalid && s_axi_bready_in) begin
      st_next.bvalid = 1'b0;
    end
    if (do_wr) begin
      st_next.bvalid = 1'b1;
      st_next.bresp  = mapped(s_axi_awaddr_in) ? sem_pkg::RESP_OKAY : sem_pkg::RESP_SLVERR;
      if (s_axi_awaddr_in == sem_pkg::OFS_COUNT_EN) begin
        st_next.count_en = lane_merge(st_reg.count_en, s_axi_wdata_in[15:0], s_axi_wstrb_in[1:0]);
      end else if (s_axi_awaddr_in == sem_pkg::OFS_LOCK_CYC) begin
        st_next.lock_cyc = lane_merge(st_reg.lock_cyc, s_axi_wdata_in[15:0], s_axi_wstrb_in[1:0]);
      end
    end
    // read channel
    st_next.arready = s_axi_arvalid_in && !st_reg.arready && !st_reg.rvalid;
    if (st_reg.rvalid && s_axi_rready_in) begin
      st_next.rvalid = 1'b0;
    end
    if (do_rd) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = sem_pkg::RESP_OKAY;
      st_next.rdata  = 32'h0000_0000;
      if (s_axi_araddr_in == sem_pkg::OFS_CONFIG) begin
        st_next.rdata[sem_pkg::CFG_PRESENT_BIT] = PKT_PROC_PRESENT;
      end else if (s_axi_araddr_in == sem_pkg::OFS_PKT_STATUS) begin
        if (PKT_PROC_PRESENT) begin
          st_next.rdata[sem_pkg::PKT_FLAGS_LSB +: 4] = st_reg.report.pkt_flags;
          st_next.rdata[sem_pkg::ANC_FLAGS_LSB +: 5] = st_reg.report.anc_flags;
          st_next.rdata[sem_pkg::FF_FLAGS_LSB +: 5]  = st_reg.report.ff_flags;
          st_next.rdata[sem_pkg::AP_FLAGS_LSB +: 5]  = st_reg.report.ap_flags;
          st_next.rdata[sem_pkg::ANC_ERR_BIT]        = st_reg.report.anc_err;
          st_next.rdata[sem_pkg::FF_ERR_BIT]         = st_reg.report.ff_err;
          st_next.rdata[sem_pkg::AP_ERR_BIT]         = st_reg.report.ap_err;
        end
      end else if (s_axi_araddr_in == sem_pkg::OFS_COUNT_EN) begin
        st_next.rdata[15:0] = st_reg.count_en;
      end else if (s_axi_araddr_in == sem_pkg::OFS_FIELD_CNT) begin
        st_next.rdata[15:0] = PKT_PROC_PRESENT ? st_reg.field_cnt : 16'h0000;
      end else if (s_axi_araddr_in == sem_pkg::OFS_STREAM_CRC) begin
        st_next.rdata = {st_reg.crc_cnt, crc_flags};
      end else if (s_axi_araddr_in == sem_pkg::OFS_LOCK_CYC) begin
        st_next.rdata[15:0] = st_reg.lock_cyc;
      end else begin
        st_next.rresp = sem_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_reg          <= '0;
      st_reg.count_en <= sem_pkg::COUNT_EN_RST;
      st_reg.lock_cyc <= sem_pkg::LOCK_CYC_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready_out = st_reg.awready;
  assign s_axi_wready_out  = st_reg.wready;
  assign s_axi_bvalid_out  = st_reg.bvalid;
  assign s_axi_bresp_out   = st_reg.bresp;
  assign s_axi_arready_out = st_reg.arready;
  assign s_axi_rvalid_out  = st_reg.rvalid;
  assign s_axi_rresp_out   = st_reg.rresp;
  assign s_axi_rdata_out   = st_reg.rdata;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  property p_pkt_capture;
    edh_report_valid_in |=> st_reg.report.pkt_flags == $past(edh_report_in.pkt_flags) &&
                            st_reg.report.ap_flags == $past(edh_report_in.ap_flags);
  endproperty
  a_pkt_capture: assert property (p_pkt_capture) else $error("packet flags not captured");
  property p_anc_err;
    edh_report_in.anc_err |=> st_reg.report.anc_err;
  endproperty
  a_anc_err: assert property (p_anc_err) else $error("checksum status not raised");
  property p_en_write;
    do_wr && s_axi_awaddr_in == sem_pkg::OFS_COUNT_EN && s_axi_wstrb_in == 4'hf
      |=> st_reg.count_en == $past(s_axi_wdata_in[15:0]);
  endproperty
  a_en_write: assert property (p_en_write) else $error("count enables not written");
  property p_field_step;
    ##1 (st_reg.field_cnt == $past(st_reg.field_cnt) ||
         st_reg.field_cnt == 16'($past(st_reg.field_cnt) + 16'h0001));
  endproperty
  a_field_step: assert property (p_field_step) else $error("field counter jumped");
  property p_field_mode;
    !sd_mode && !st_reg.field_hit && field_start_in |=> $stable(st_reg.field_cnt);
  endproperty
  a_field_mode: assert property (p_field_mode) else $error("field counted outside sd mode");
  property p_crc_sum;
    ##1 st_reg.crc_cnt == 16'($past(st_reg.crc_cnt) + {11'h000, $past(err_ones)});
  endproperty
  a_crc_sum: assert property (p_crc_sum) else $error("cumulative crc count wrong");
  property p_cfg_read;
    do_rd && s_axi_araddr_in == sem_pkg::OFS_CONFIG
      |=> s_axi_rvalid_out && s_axi_rdata_out == {30'h0, PKT_PROC_PRESENT, 1'b0};
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("config bit misread");
  property p_rsv_zero;
    do_rd && (s_axi_araddr_in == sem_pkg::OFS_COUNT_EN || s_axi_araddr_in == sem_pkg::OFS_LOCK_CYC)
      |=> s_axi_rdata_out[31:16] == 16'h0000;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits not zero");
endmodule // sem_error_monitor

// *** common/sem_pkg.sv ***
// shared constants and types of the receive error monitor
package sem_pkg;
  localparam int         ADDR_W          = 8;
  localparam int         NUM_STREAMS     = 16;
  localparam logic [7:0] OFS_CONFIG      = 8'h40;
  localparam logic [7:0] OFS_PKT_STATUS  = 8'h4c;
  localparam logic [7:0] OFS_COUNT_EN    = 8'h50;
  localparam logic [7:0] OFS_FIELD_CNT   = 8'h54;
  localparam logic [7:0] OFS_STREAM_CRC  = 8'h58;
  localparam logic [7:0] OFS_LOCK_CYC    = 8'h5c;
  localparam int         PKT_FLAGS_LSB   = 19;
  localparam int         ANC_FLAGS_LSB   = 14;
  localparam int         FF_FLAGS_LSB    = 9;
  localparam int         AP_FLAGS_LSB    = 4;
  localparam int         ANC_ERR_BIT     = 2;
  localparam int         FF_ERR_BIT      = 1;
  localparam int         AP_ERR_BIT      = 0;
  localparam int         CFG_PRESENT_BIT = 1;
  localparam int         CHKSUM_EN_BIT   = 15;
  localparam int         CRC_CNT_LSB     = 16;
  localparam logic [2:0] MODE_SD         = 3'h1;
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;
  localparam logic [15:0] COUNT_EN_RST   = 16'h0000;
  localparam logic [15:0] LOCK_CYC_RST   = 16'h0000;

  // report of the packet processor; flag groups ordered ues, ida, idh, eda, edh from msb
  typedef struct packed {
    logic [3:0] pkt_flags;
    logic [4:0] anc_flags;
    logic [4:0] ff_flags;
    logic [4:0] ap_flags;
    logic       anc_err;
    logic       ff_err;
    logic       ap_err;
  } sem_edh_report_s;

  typedef struct packed {
    sem_edh_report_s report;
    logic [15:0]     count_en;
    logic [15:0]     field_cnt;
    logic            field_hit;
    logic [15:0]     crc_cnt;
    logic [15:0]     lock_cyc;
    logic            awready;
    logic            wready;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            arready;
    logic            rvalid;
    logic [1:0]      rresp;
    logic [31:0]     rdata;
  } sem_main_s;

  typedef struct packed {
    logic flag;
    logic boundary_seen;
  } sem_flag_s;

  typedef struct packed {
    logic [15:0] count;
    logic        locked;
  } sem_lock_s;
endpackage

// *** hdl/sem_stream_flag.sv ***
// one per-stream crc error indicator with line-time hold and write-one clear
`timescale 1ns/1ps
module sem_stream_flag (
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  input  wire logic err_in,
  input  wire logic clear_in,
  input  wire logic line_end_in,
  output logic      flag_out
);
  sem_pkg::sem_flag_s st_reg;
  sem_pkg::sem_flag_s st_next;

  always_comb begin
    st_next = st_reg;
    if (err_in) begin
      st_next.flag          = 1'b1;
      st_next.boundary_seen = 1'b0;
    end else if (clear_in) begin
      st_next.flag = 1'b0;
    end else if (line_end_in && st_reg.flag) begin
      if (st_reg.boundary_seen) begin
        st_next.flag = 1'b0;
      end else begin
        st_next.boundary_seen = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign flag_out = st_reg.flag;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_flag_fresh;
    st_reg.flag && !st_reg.boundary_seen && line_end_in && !clear_in && !err_in;
  endsequence
  property p_flag_set;
    err_in |=> st_reg.flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("error did not raise stream flag");
  property p_flag_clear;
    clear_in && !err_in |=> !st_reg.flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("write one did not clear flag");
  property p_flag_hold;
    s_flag_fresh |=> st_reg.flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped before one line time");
endmodule // sem_stream_flag

// *** hdl/sem_lock_timer.sv ***
// counts stable video cycles and declares lock
`timescale 1ns/1ps
module sem_lock_timer (
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        stable_in,
  input  wire logic [15:0] window_in,
  output logic             locked_out
);
  sem_pkg::sem_lock_s st_reg;
  sem_pkg::sem_lock_s st_next;

  always_comb begin
    st_next = st_reg;
    if (!stable_in) begin
      st_next.count  = 16'h0000;
      st_next.locked = 1'b0;
    end else if (st_reg.count < window_in) begin
      st_next.count = st_reg.count + 16'h0001;
    end else begin
      st_next.locked = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign locked_out = st_reg.locked;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  property p_lock_drop;
    !stable_in |=> !st_reg.locked && st_reg.count == 16'h0000;
  endproperty
  a_lock_drop: assert property (p_lock_drop) else $error("lock kept through instability");
  property p_lock_rise;
    $rose(st_reg.locked) |-> $past(st_reg.count) >= $past(window_in) && $past(stable_in);
  endproperty
  a_lock_rise: assert property (p_lock_rise) else $error("lock before stable window elapsed");
endmodule // sem_lock_timer

// *** verif/sem_video_src.sv ***
// upstream video source model driving the monitor's error, field, line and stability inputs
`timescale 1ns/1ps
module sem_video_src (
  input  wire logic                clk_in,
  output logic [2:0]               mode_out,
  output sem_pkg::sem_edh_report_s report_out,
  output logic                     report_valid_out,
  output logic                     checksum_err_out,
  output logic                     field_start_out,
  output logic [15:0]              crc_err_out,
  output logic                     line_end_out,
  output logic                     stable_out
);
  // ****************************************
  // idle levels
  // ****************************************
  initial begin
    mode_out         = 3'h0;
    report_out       = '0;
    report_valid_out = 1'b0;
    checksum_err_out = 1'b0;
    field_start_out  = 1'b0;
    crc_err_out      = 16'h0000;
    line_end_out     = 1'b0;
    stable_out       = 1'b0;
  end
  // ****************************************
  // stimulus tasks, all changes on the falling edge
  // ****************************************
  task automatic set_level(input logic [2:0] mode, input logic stable);
    @(negedge clk_in);
    mode_out   = mode;
    stable_out = stable;
  endtask
  // flag groups only mean something with the strobe, so they are scrambled afterwards
  task automatic send_report(input sem_pkg::sem_edh_report_s rep);
    @(negedge clk_in);
    report_out       = rep;
    report_valid_out = 1'b1;
    @(negedge clk_in);
    report_valid_out = 1'b0;
    report_out[21:3] = ~rep[21:3];
  endtask
  // one-cycle pulse: 0 packet checksum error, 1 field boundary, 2 line end
  task automatic pulse_sig(input int sel);
    @(negedge clk_in);
    checksum_err_out = (sel == 0);
    field_start_out  = (sel == 1);
    line_end_out     = (sel == 2);
    @(negedge clk_in);
    checksum_err_out = 1'b0;
    field_start_out  = 1'b0;
    line_end_out     = 1'b0;
  endtask
  task automatic pulse_crc(input logic [15:0] v);
    @(negedge clk_in);
    crc_err_out = v;
    @(negedge clk_in);
    crc_err_out = 16'h0000;
  endtask
endmodule // sem_video_src

// *** verif/sem_error_monitor_tb.sv ***
// self-checking bench of the receive error monitor register group
`timescale 1ns/1ps
module sem_error_monitor_tb;
  // ****************************************
  // signals
  // ****************************************
  localparam int         LIMIT = 20000;
  localparam logic [1:0] OK    = sem_pkg::RESP_OKAY;
  localparam logic [1:0] ERR   = sem_pkg::RESP_SLVERR;
  logic                     clk_in = 1'b0;
  logic                     reset_n_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
  logic                     s_axi_arvalid_in, s_axi_rready_in, s_axi_awready_out, s_axi_wready_out;
  logic                     s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  logic                     edh_report_valid_in, packet_checksum_err_in, field_start_in;
  logic                     line_end_in, video_stable_in, video_lock_out;
  logic [1:0]               s_axi_bresp_out, s_axi_rresp_out;
  logic [2:0]               rx_mode_in;
  logic [3:0]               s_axi_wstrb_in;
  logic [7:0]               s_axi_awaddr_in, s_axi_araddr_in;
  logic [15:0]              stream_crc_err_in;
  logic [31:0]              s_axi_wdata_in, s_axi_rdata_out;
  sem_pkg::sem_edh_report_s edh_report_in, rep;
  logic [14:0]              hot;
  int                       failures = 0;
  int                       n_checks = 0;
  int                       cycles   = 0;

  always #12.5 clk_in = ~clk_in;

  sem_error_monitor u_dut (
    .clk_in                 (clk_in),
    .reset_n_in             (reset_n_in),
    .s_axi_awaddr_in        (s_axi_awaddr_in),
    .s_axi_awvalid_in       (s_axi_awvalid_in),
    .s_axi_awready_out      (s_axi_awready_out),
    .s_axi_wdata_in         (s_axi_wdata_in),
    .s_axi_wstrb_in         (s_axi_wstrb_in),
    .s_axi_wvalid_in        (s_axi_wvalid_in),
    .s_axi_wready_out       (s_axi_wready_out),
    .s_axi_bresp_out        (s_axi_bresp_out),
    .s_axi_bvalid_out       (s_axi_bvalid_out),
    .s_axi_bready_in        (s_axi_bready_in),
    .s_axi_araddr_in        (s_axi_araddr_in),
    .s_axi_arvalid_in       (s_axi_arvalid_in),
    .s_axi_arready_out      (s_axi_arready_out),
    .s_axi_rdata_out        (s_axi_rdata_out),
    .s_axi_rresp_out        (s_axi_rresp_out),
    .s_axi_rvalid_out       (s_axi_rvalid_out),
    .s_axi_rready_in        (s_axi_rready_in),
    .rx_mode_in             (rx_mode_in),
    .edh_report_in          (edh_report_in),
    .edh_report_valid_in    (edh_report_valid_in),
    .packet_checksum_err_in (packet_checksum_err_in),
    .field_start_in         (field_start_in),
    .stream_crc_err_in      (stream_crc_err_in),
    .line_end_in            (line_end_in),
    .video_stable_in        (video_stable_in),
    .video_lock_out         (video_lock_out)
  );

  sem_video_src u_src (
    .clk_in           (clk_in),
    .mode_out         (rx_mode_in),
    .report_out       (edh_report_in),
    .report_valid_out (edh_report_valid_in),
    .checksum_err_out (packet_checksum_err_in),
    .field_start_out  (field_start_in),
    .crc_err_out      (stream_crc_err_in),
    .line_end_out     (line_end_in),
    .stable_out       (video_stable_in)
  );

  // ****************************************
  // compare, bus and closing tasks
  // ****************************************
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk2(input logic [1:0] got, input logic [1:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    @(negedge clk_in);
    s_axi_awaddr_in  = a;
    s_axi_wdata_in   = d;
    s_axi_wstrb_in   = s;
    s_axi_awvalid_in = 1'b1;
    s_axi_wvalid_in  = 1'b1;
    s_axi_bready_in  = 1'b1;
    @(negedge clk_in);
    while (s_axi_awready_out !== 1'b1) @(negedge clk_in);
    chk2({1'b0, s_axi_wready_out}, 2'h1, "write ready");
    @(negedge clk_in);
    s_axi_awvalid_in = 1'b0;
    s_axi_wvalid_in  = 1'b0;
    s_axi_awaddr_in  = ~a;
    s_axi_wdata_in   = ~d;
    while (s_axi_bvalid_out !== 1'b1) @(negedge clk_in);
    chk2(s_axi_bresp_out, er, "write response");
    @(negedge clk_in);
    s_axi_bready_in = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(negedge clk_in);
    s_axi_araddr_in  = a;
    s_axi_arvalid_in = 1'b1;
    s_axi_rready_in  = 1'b1;
    @(negedge clk_in);
    while (s_axi_arready_out !== 1'b1) @(negedge clk_in);
    @(negedge clk_in);
    s_axi_arvalid_in = 1'b0;
    s_axi_araddr_in  = ~a;
    while (s_axi_rvalid_out !== 1'b1) @(negedge clk_in);
    chk32(s_axi_rdata_out, ed, "read data");
    chk2(s_axi_rresp_out, er, "read response");
    @(negedge clk_in);
    s_axi_rready_in = 1'b0;
  endtask

  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failures++;
      wrap_up();
    end
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    reset_n_in       = 1'b0;
    s_axi_awaddr_in  = 8'h00;
    s_axi_wdata_in   = 32'h0000_0000;
    s_axi_wstrb_in   = 4'hf;
    s_axi_awvalid_in = 1'b0;
    s_axi_wvalid_in  = 1'b0;
    s_axi_bready_in  = 1'b0;
    s_axi_araddr_in  = 8'h00;
    s_axi_arvalid_in = 1'b0;
    s_axi_rready_in  = 1'b0;
    repeat (6) @(negedge clk_in);
    reset_n_in = 1'b1;
    rd(sem_pkg::OFS_CONFIG, 32'h0000_0002, OK);
    for (int i = 0; i < 5; i++) rd(8'h4c + 8'(4 * i), 32'h0000_0000, OK);
    rd(8'h60, 32'h0000_0000, ERR);
    wr(8'h60, 32'hffff_ffff, 4'hf, ERR);
    $display("test reset_values done");
    for (int i = 0; i < 2; i++) begin
      rep = (i == 0) ? 22'h2b5a5d : 22'h14a5a2;
      u_src.send_report(rep);
      rd(sem_pkg::OFS_PKT_STATUS, {9'h000, rep[21:3], 1'b0, rep[2:0]}, OK);
    end
    wr(sem_pkg::OFS_PKT_STATUS, 32'hffff_ffff, 4'hf, OK);
    rd(sem_pkg::OFS_PKT_STATUS, {9'h000, rep[21:3], 1'b0, rep[2:0]}, OK);
    $display("test packet_status done");
    wr(sem_pkg::OFS_COUNT_EN, 32'hffff_ffff, 4'hf, OK);
    rd(sem_pkg::OFS_COUNT_EN, 32'h0000_ffff, OK);
    wr(sem_pkg::OFS_LOCK_CYC, 32'h1234_5678, 4'h1, OK);
    rd(sem_pkg::OFS_LOCK_CYC, 32'h0000_0078, OK);
    wr(sem_pkg::OFS_LOCK_CYC, 32'h1234_5678, 4'hf, OK);
    rd(sem_pkg::OFS_LOCK_CYC, 32'h0000_5678, OK);
    $display("test read_write done");
    u_src.set_level(sem_pkg::MODE_SD, 1'b0);
    for (int i = 0; i < 16; i++) begin
      wr(sem_pkg::OFS_COUNT_EN, 32'h1 << i, 4'hf, OK);
      hot           = 15'h0001 << i;
      rep           = '0;
      rep.ap_flags  = hot[14:10];
      rep.ff_flags  = hot[9:5];
      rep.anc_flags = hot[4:0];
      for (int k = 0; k < 2; k++) begin
        if (i == 15) u_src.pulse_sig(0);
        else u_src.send_report(rep);
      end
      u_src.pulse_sig(1);
      rd(sem_pkg::OFS_FIELD_CNT, 32'(i + 1), OK);
    end
    u_src.send_report(22'h3ffff8);
    u_src.pulse_sig(1);
    rd(sem_pkg::OFS_FIELD_CNT, 32'h0000_0010, OK);
    u_src.set_level(3'h0, 1'b0);
    u_src.pulse_sig(0);
    u_src.pulse_sig(1);
    rd(sem_pkg::OFS_FIELD_CNT, 32'h0000_0010, OK);
    $display("test field_counter done");
    u_src.pulse_crc(16'h8001);
    u_src.pulse_crc(16'h0800);
    rd(sem_pkg::OFS_STREAM_CRC, 32'h0003_8801, OK);
    wr(sem_pkg::OFS_STREAM_CRC, 32'hffff_0001, 4'hf, OK);
    rd(sem_pkg::OFS_STREAM_CRC, 32'h0003_8800, OK);
    wr(sem_pkg::OFS_STREAM_CRC, 32'h0000_0000, 4'hf, OK);
    rd(sem_pkg::OFS_STREAM_CRC, 32'h0003_8800, OK);
    u_src.pulse_sig(2);
    rd(sem_pkg::OFS_STREAM_CRC, 32'h0003_8800, OK);
    u_src.pulse_sig(2);
    rd(sem_pkg::OFS_STREAM_CRC, 32'h0003_0000, OK);
    $display("test stream_crc done");
    wr(sem_pkg::OFS_LOCK_CYC, 32'h0000_0005, 4'hf, OK);
    for (int k = 0; k < 2; k++) begin
      u_src.set_level(sem_pkg::MODE_SD, 1'b1);
      repeat (5) @(negedge clk_in);
      chk32({31'h0, video_lock_out}, 32'h0, "lock early");
      @(negedge clk_in);
      chk32({31'h0, video_lock_out}, 32'h1, "lock");
      u_src.set_level(sem_pkg::MODE_SD, 1'b0);
      @(negedge clk_in);
      chk32({31'h0, video_lock_out}, 32'h0, "lock drop");
    end
    $display("test video_lock done");
    wrap_up();
  end
endmodule // sem_error_monitor_tb
